// File: dcd_consts.vh
`ifndef DCD_CONSTS_VH
`define DCD_CONSTS_VH
// ****************************************
// Instruction fields and opcodes
// ****************************************
`define DCD_F_OP    23:20
`define DCD_F_RD    19:16
`define DCD_F_RA    15:12
`define DCD_F_RB    11:8
`define DCD_F_FN    7:4
`define DCD_F_AM    9:8
`define DCD_F_IMM   15:0
`define DCD_F_TGT   19:0
`define DCD_F_DOCNT 19:10
`define DCD_F_DOLEN 9:0
`define DCD_F_RPT   13:0
`define DCD_F_ACC   19
`define DCD_F_SAT   18
`define DCD_F_PFX   17
`define DCD_F_MAM   16:15
`define DCD_F_SAMT  17:12
`define DCD_OP_ALU  4'h1
`define DCD_OP_LD   4'h2
`define DCD_OP_ST   4'h3
`define DCD_OP_MAC  4'h4
`define DCD_OP_SFT  4'h5
`define DCD_OP_BRA  4'h6
`define DCD_OP_CALL 4'h7
`define DCD_OP_RET  4'h8
`define DCD_OP_DO   4'h9
`define DCD_OP_RPT  4'ha
`define DCD_OP_MOVD 4'hb
`define DCD_OP_MOVI 4'hc
`define DCD_FN_ADD  4'h0
`define DCD_FN_SUB  4'h1
`define DCD_FN_AND  4'h2
`define DCD_FN_OR   4'h3
`define DCD_FN_XOR  4'h4
`define DCD_FN_MOV  4'h5
// ****************************************
// Address generation
// ****************************************
`define DCD_AM_NONE 2'h0
`define DCD_AM_INC  2'h1
`define DCD_AM_MOD  2'h2
`define DCD_AM_REV  2'h3
`define DCD_WSTEP   16'h0002
`define DCD_PCSTEP  23'h000002
`define DCD_PSV_BIT 15
`define DCD_DMA_LO  16'h4000
`define DCD_DMA_HI  16'h47ff
`define DCD_Y_BASE  16'h2000
// ****************************************
// Registers, reset values, DSP
// ****************************************
`define DCD_SP_IDX  4'hf
`define DCD_XP_IDX  4'h8
`define DCD_YP_IDX  4'ha
`define DCD_XD_IDX  4'h4
`define DCD_YD_IDX  4'h5
`define DCD_W_RST   16'h0000
`define DCD_SP_RST  16'h0800
`define DCD_PC_RST  23'h000000
`define DCD_ACC_RST 40'h0000000000
`define DCD_ACC_MAX 40'h7fffffffff
`define DCD_ACC_MIN 40'h8000000000
`define DCD_SFT_LIM 6'h10
`define DCD_DSP_NOP 2'h0
`define DCD_DSP_MAC 2'h1
`define DCD_DSP_SFT 2'h2
`endif

// File: dcd_agu.v
`timescale 1ns/10ps
`include "dcd_consts.vh"
module dcd_agu (
    input  wire [15:0] ptr,
    input  wire [1:0]  mode,
    input  wire [15:0] mod_start,
    input  wire [15:0] mod_end,
    input  wire [15:0] rev_mod,
    output wire [15:0] ea,
    output reg  [15:0] next_ptr
);
    // Bit order reversal, used three times for the reverse-carry add
    function [15:0] rev16(input [15:0] v);
        integer k;
        begin
            for (k = 0; k < 16; k = k + 1) begin
                rev16[k] = v[15-k];
            end
        end
    endfunction

    assign ea = ptr;

    // Post-modify; modulo wraps in hardware, no software bound check
    always @* begin
        case (mode)
            `DCD_AM_INC: next_ptr = ptr + `DCD_WSTEP;
            `DCD_AM_MOD: begin
                if (ptr == mod_end) begin
                    next_ptr = mod_start;
                end else begin
                    next_ptr = ptr + `DCD_WSTEP;
                end
            end
            `DCD_AM_REV: next_ptr = rev16(rev16(ptr) + rev16(rev_mod));
            default:     next_ptr = ptr;
        endcase
    end
endmodule // dcd_agu

// File: dcd_dsp.v
`timescale 1ns/10ps
`include "dcd_consts.vh"
module dcd_dsp (
    input  wire        clk_sys,
    input  wire        reset,
    input  wire [1:0]  op,
    input  wire        acc_sel,
    input  wire        sat_en,
    input  wire [15:0] mul_a,
    input  wire [15:0] mul_b,
    input  wire [5:0]  sft_amt,
    output reg  [39:0] acc_a_q,
    output reg  [39:0] acc_b_q
);
    wire signed [16:0] op_a = {mul_a[15], mul_a};
    wire signed [16:0] op_b = {mul_b[15], mul_b};
    wire signed [33:0] prod = op_a * op_b;
    wire [39:0] acc_cur = acc_sel ? acc_b_q : acc_a_q;
    wire [40:0] sum = {acc_cur[39], acc_cur} +
                      {{7{prod[33]}}, prod};
    reg  [39:0] res;

    // Clamp on 40-bit overflow when saturation is asked for
    function [39:0] sat40(input [40:0] s, input en);
        begin
            if (en && (s[40] != s[39])) begin
                sat40 = s[40] ? `DCD_ACC_MIN : `DCD_ACC_MAX;
            end else begin
                sat40 = s[39:0];
            end
        end
    endfunction

    // Positive amount shifts left, negative shifts right arithmetic
    function [39:0] shf40(input [39:0] v, input [5:0] a);
        reg [5:0] mag;
        begin
            mag = a[5] ? (~a + 6'h01) : a;
            if (mag > `DCD_SFT_LIM) begin
                shf40 = v;
            end else if (a[5]) begin
                shf40 = $signed(v) >>> mag;
            end else begin
                shf40 = v << mag;
            end
        end
    endfunction

    always @* begin
        if (op == `DCD_DSP_SFT) begin
            res = shf40(acc_cur, sft_amt);
        end else begin
            res = sat40(sum, sat_en);
        end
    end

    // Result lands in the selected accumulator on the next rising clock edge
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            acc_a_q <= `DCD_ACC_RST;
            acc_b_q <= `DCD_ACC_RST;
        end else if (op != `DCD_DSP_NOP) begin
            if (acc_sel) begin
                acc_b_q <= res;
            end else begin
                acc_a_q <= res;
            end
        end
    end
endmodule // dcd_dsp

// File: dsp_cpu_datapath.v
`timescale 1ns/10ps
`include "dcd_consts.vh"
module dsp_cpu_datapath #(
    parameter [15:0] Y_BASE = `DCD_Y_BASE
) (
    input  wire        clk_sys,
    input  wire        reset,
    output wire [22:0] pm_addr,
    input  wire [23:0] pm_rdata,
    output wire [15:0] dx_addr,
    input  wire [15:0] dx_rdata,
    output reg  [15:0] dx_wdata,
    output reg         dx_we,
    output reg         dx_re,
    output wire [15:0] dy_addr,
    input  wire [15:0] dy_rdata,
    output wire        dy_re,
    output wire        dma_region_hit,
    input  wire        psv_enable,
    input  wire [7:0]  program_window_page,
    input  wire [15:0] xmod_start,
    input  wire [15:0] xmod_end,
    input  wire [15:0] ymod_start,
    input  wire [15:0] ymod_end,
    input  wire [15:0] rev_mod,
    input  wire        irq,
    input  wire [22:0] irq_vector,
    output reg         irq_ack,
    output wire [39:0] acc_a,
    output wire [39:0] acc_b
);
    // ****************************************
    // States and storage
    // ****************************************
    localparam [2:0] S_RUN   = 3'h0;
    localparam [2:0] S_PUSH2 = 3'h1;
    localparam [2:0] S_POP2  = 3'h2;
    localparam [2:0] S_MOVD2 = 3'h3;
    localparam [2:0] S_PSV   = 3'h4;

    reg  [2:0]  st_q;
    reg  [22:0] pc_q;
    reg  [23:0] ir_q;
    reg  [22:0] ir_pc_q;
    reg         ir_valid_q;
    reg  [15:0] w_q [0:15];
    reg  [13:0] rpt_q;
    reg  [22:0] lp_start_q;
    reg  [22:0] lp_end_q;
    reg  [9:0]  lp_cnt_q;
    reg         lp_on_q;
    reg  [22:0] ret_q;
    reg  [22:0] tgt_q;
    integer     i;

    // ****************************************
    // Decode
    // ****************************************
    wire [3:0]  op  = ir_q[`DCD_F_OP];
    wire [3:0]  rd  = ir_q[`DCD_F_RD];
    wire [3:0]  ra  = ir_q[`DCD_F_RA];
    wire [3:0]  rb  = ir_q[`DCD_F_RB];
    wire [1:0]  am  = ir_q[`DCD_F_AM];
    wire [15:0] spv = w_q[`DCD_SP_IDX];
    wire [15:0] spm = spv - `DCD_WSTEP;
    wire        run = (st_q == S_RUN) && ir_valid_q;
    wire        go  = run && !irq;
    wire        mac_go = go && (op == `DCD_OP_MAC);
    wire [22:0] jmp = {2'h0, ir_q[`DCD_F_TGT], 1'h0};
    wire [22:0] ir_nxt = ir_pc_q + `DCD_PCSTEP;

    // Loop end redirects the fetch itself, so no branch bubble
    wire        lp_wrap = lp_on_q && (pc_q == lp_end_q) &&
                          (lp_cnt_q != 10'h000);
    wire [22:0] fetch_nxt = lp_wrap ? lp_start_q
                                    : pc_q + `DCD_PCSTEP;

    // Three-operand ALU
    function [15:0] alu_f(input [3:0] fn, input [15:0] a,
                          input [15:0] b);
        begin
            case (fn)
                `DCD_FN_ADD: alu_f = a + b;
                `DCD_FN_SUB: alu_f = a - b;
                `DCD_FN_AND: alu_f = a & b;
                `DCD_FN_OR:  alu_f = a | b;
                `DCD_FN_XOR: alu_f = a ^ b;
                `DCD_FN_MOV: alu_f = a;
                default:     alu_f = b;
            endcase
        end
    endfunction

    // ****************************************
    // X address source selection
    // ****************************************
    reg  [15:0] x_ptr;
    reg  [1:0]  x_mode;
    wire [15:0] x_ea;
    wire [15:0] x_next;
    wire [15:0] y_ea;
    wire [15:0] y_next;

    // Stack traffic goes through the X generator on register fifteen
    always @* begin
        x_ptr  = w_q[ra];
        x_mode = `DCD_AM_NONE;
        if (st_q == S_PUSH2) begin
            x_ptr = spv;
        end else if (st_q == S_POP2) begin
            x_ptr = spm;
        end else if (st_q == S_MOVD2) begin
            x_ptr  = w_q[ra] + `DCD_WSTEP;
            x_mode = am;
        end else if (st_q == S_PSV) begin
            x_mode = am;
        end else if (run && irq) begin
            x_ptr = spv;
        end else if (op == `DCD_OP_CALL) begin
            x_ptr = spv;
        end else if (op == `DCD_OP_RET) begin
            x_ptr = spm;
        end else if (op == `DCD_OP_MAC) begin
            x_ptr  = w_q[`DCD_XP_IDX];
            x_mode = ir_q[`DCD_F_MAM];
        end else if (op == `DCD_OP_LD || op == `DCD_OP_ST) begin
            x_mode = am;
        end
    end

    dcd_agu u_agu_x (
        .ptr       (x_ptr),
        .mode      (x_mode),
        .mod_start (xmod_start),
        .mod_end   (xmod_end),
        .rev_mod   (rev_mod),
        .ea        (x_ea),
        .next_ptr  (x_next)
    );

    // Y generator has no bit-reverse; all but modulo step one word
    wire [1:0]  y_mode = (ir_q[`DCD_F_MAM] == `DCD_AM_MOD) ? `DCD_AM_MOD
                                                            : `DCD_AM_INC;

    dcd_agu u_agu_y (
        .ptr       (w_q[`DCD_YP_IDX]),
        .mode      (y_mode),
        .mod_start (ymod_start),
        .mod_end   (ymod_end),
        .rev_mod   (`DCD_W_RST),
        .ea        (y_ea),
        .next_ptr  (y_next)
    );

    // Program window: bit 15 selects it; the page plus bits 14:0 form a 23-bit program address
    wire        psv_hit  = psv_enable && x_ea[`DCD_PSV_BIT];
    wire [22:0] psv_addr = {program_window_page, x_ea[14:0]};
    wire        y_ok     = (y_ea >= Y_BASE);

    assign pm_addr = (st_q == S_PSV) ? psv_addr : pc_q;
    assign dx_addr = x_ea;
    assign dy_addr = y_ea;
    assign dy_re   = mac_go && ir_q[`DCD_F_PFX] && y_ok;
    assign dma_region_hit = (dx_re || dx_we) && (x_ea >= `DCD_DMA_LO) &&
                            (x_ea <= `DCD_DMA_HI);

    // ****************************************
    // Data port strobes
    // ****************************************
    // The window is read-only; stores into it are dropped
    always @* begin
        dx_we    = 1'b0;
        dx_re    = 1'b0;
        dx_wdata = w_q[rd];
        if (st_q == S_PUSH2) begin
            dx_we    = 1'b1;
            dx_wdata = {9'h000, ret_q[22:16]};
        end else if (st_q == S_POP2) begin
            dx_re = 1'b1;
        end else if (st_q == S_MOVD2) begin
            dx_re = 1'b1;
        end else if (run && irq) begin
            dx_we    = 1'b1;
            dx_wdata = ir_pc_q[15:0];
        end else if (run) begin
            case (op)
                `DCD_OP_CALL: begin
                    dx_we    = 1'b1;
                    dx_wdata = ir_nxt[15:0];
                end
                `DCD_OP_ST:   dx_we = !psv_hit;
                `DCD_OP_LD:   dx_re = !psv_hit;
                `DCD_OP_MOVD: dx_re = !psv_hit;
                `DCD_OP_RET:  dx_re = 1'b1;
                `DCD_OP_MAC:  dx_re = ir_q[`DCD_F_PFX];
                default:      dx_re = 1'b0;
            endcase
        end
    end

    // ****************************************
    // DSP engine
    // ****************************************
    wire [1:0] dsp_op = mac_go ? `DCD_DSP_MAC :
                        (go && op == `DCD_OP_SFT) ? `DCD_DSP_SFT
                                                  : `DCD_DSP_NOP;

    dcd_dsp u_dsp (
        .clk_sys (clk_sys),
        .reset   (reset),
        .op      (dsp_op),
        .acc_sel (ir_q[`DCD_F_ACC]),
        .sat_en  (ir_q[`DCD_F_SAT]),
        .mul_a   (w_q[`DCD_XD_IDX]),
        .mul_b   (w_q[`DCD_YD_IDX]),
        .sft_amt (ir_q[`DCD_F_SAMT]),
        .acc_a_q (acc_a),
        .acc_b_q (acc_b)
    );

    // ****************************************
    // Fetch and sequencing
    // ****************************************
    // Take the prefetched word; retire loop bookkeeping for the old one
    task do_fetch;
        begin
            ir_q       <= pm_rdata;
            ir_pc_q    <= pc_q;
            pc_q       <= fetch_nxt;
            ir_valid_q <= 1'b1;
            if (ir_valid_q && lp_on_q && ir_pc_q == lp_end_q) begin
                if (lp_cnt_q != 10'h000) begin
                    lp_cnt_q <= lp_cnt_q - 10'h001;
                end else begin
                    lp_on_q <= 1'b0;
                end
            end
        end
    endtask

    // A repeated word stays in place while the count runs down
    task advance;
        begin
            if (rpt_q != 14'h0000) begin
                rpt_q <= rpt_q - 14'h0001;
            end else begin
                do_fetch;
            end
        end
    endtask

    // Main sequencer; register file writes share this process
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_q       <= S_RUN;
            pc_q       <= `DCD_PC_RST;
            ir_q       <= 24'h000000;
            ir_pc_q    <= `DCD_PC_RST;
            ir_valid_q <= 1'b0;
            rpt_q      <= 14'h0000;
            lp_start_q <= `DCD_PC_RST;
            lp_end_q   <= `DCD_PC_RST;
            lp_cnt_q   <= 10'h000;
            lp_on_q    <= 1'b0;
            ret_q      <= `DCD_PC_RST;
            tgt_q      <= `DCD_PC_RST;
            irq_ack    <= 1'b0;
            for (i = 0; i < 16; i = i + 1) begin
                w_q[i] <= `DCD_W_RST;
            end
            w_q[`DCD_SP_IDX] <= `DCD_SP_RST;
        end else begin
            irq_ack <= 1'b0;
            case (st_q)
                S_RUN: begin
                    if (!ir_valid_q) begin
                        do_fetch;
                    end else if (irq) begin
                        // Any boundary, loops included; the unexecuted
                        // word is saved, but rpt_q is not, so a pending repeat falls on the handler's first advancing word
                        ret_q            <= ir_pc_q;
                        tgt_q            <= irq_vector;
                        w_q[`DCD_SP_IDX] <= spv + `DCD_WSTEP;
                        irq_ack          <= 1'b1;
                        st_q             <= S_PUSH2;
                    end else begin
                        case (op)
                            `DCD_OP_ALU: begin
                                w_q[rd] <= alu_f(ir_q[`DCD_F_FN], w_q[ra],
                                                 w_q[rb]);
                                advance;
                            end
                            `DCD_OP_MOVI: begin
                                w_q[rd] <= ir_q[`DCD_F_IMM];
                                advance;
                            end
                            `DCD_OP_LD: begin
                                if (psv_hit) begin
                                    st_q <= S_PSV;
                                end else begin
                                    w_q[ra] <= x_next;
                                    w_q[rd] <= dx_rdata;
                                    advance;
                                end
                            end
                            `DCD_OP_ST: begin
                                w_q[ra] <= x_next;
                                advance;
                            end
                            `DCD_OP_MAC: begin
                                w_q[`DCD_XP_IDX] <= x_next;
                                w_q[`DCD_YP_IDX] <= y_next;
                                if (ir_q[`DCD_F_PFX]) begin
                                    w_q[`DCD_XD_IDX] <= dx_rdata;
                                    w_q[`DCD_YD_IDX] <= y_ok ? dy_rdata
                                                             : `DCD_W_RST;
                                end
                                advance;
                            end
                            `DCD_OP_BRA: begin
                                pc_q       <= jmp;
                                ir_valid_q <= 1'b0;
                            end
                            `DCD_OP_CALL: begin
                                ret_q            <= ir_nxt;
                                tgt_q            <= jmp;
                                w_q[`DCD_SP_IDX] <= spv + `DCD_WSTEP;
                                st_q             <= S_PUSH2;
                            end
                            `DCD_OP_RET: begin
                                ret_q[22:16]     <= dx_rdata[6:0];
                                w_q[`DCD_SP_IDX] <= spm;
                                st_q             <= S_POP2;
                            end
                            `DCD_OP_DO: begin
                                do_fetch;
                                lp_start_q <= pc_q;
                                lp_end_q   <= ir_pc_q +
                                    {12'h000, ir_q[`DCD_F_DOLEN], 1'h0};
                                lp_cnt_q   <= ir_q[`DCD_F_DOCNT];
                                lp_on_q    <= 1'b1;
                            end
                            `DCD_OP_RPT: begin
                                do_fetch;
                                rpt_q <= ir_q[`DCD_F_RPT];
                            end
                            `DCD_OP_MOVD: begin
                                if (psv_hit) begin
                                    st_q <= S_PSV;
                                end else begin
                                    w_q[rd] <= dx_rdata;
                                    st_q    <= S_MOVD2;
                                end
                            end
                            default: advance;
                        endcase
                    end
                end
                S_PUSH2: begin
                    w_q[`DCD_SP_IDX] <= spv + `DCD_WSTEP;
                    pc_q       <= tgt_q;
                    ir_valid_q <= 1'b0;
                    st_q       <= S_RUN;
                end
                S_POP2: begin
                    w_q[`DCD_SP_IDX] <= spm;
                    pc_q       <= {ret_q[22:16], dx_rdata};
                    ir_valid_q <= 1'b0;
                    st_q       <= S_RUN;
                end
                S_MOVD2: begin
                    if (am != `DCD_AM_NONE) begin
                        w_q[ra] <= x_next;
                    end
                    w_q[rd + 4'h1] <= dx_rdata;
                    st_q <= S_RUN;
                    advance;
                end
                S_PSV: begin
                    // Fetch port was lent to the data read; refetch next unless a repeat is still counting down
                    w_q[ra] <= x_next;
                    w_q[rd] <= pm_rdata[15:0];
                    if (rpt_q != 14'h0000) begin
                        rpt_q <= rpt_q - 14'h0001;
                    end else begin
                        ir_valid_q <= 1'b0;
                    end
                    st_q <= S_RUN;
                end
                default: st_q <= S_RUN;
            endcase
        end
    end
endmodule // dsp_cpu_datapath

// File: dsp_cpu_datapath_chk.sv
`timescale 1ns/10ps
// ****************************************
// Port checker
// ****************************************
module dcd_chk #(
    parameter [15:0] Y_BASE = 16'h2000
) (
    input wire        clk_sys,
    input wire        reset,
    input wire [22:0] pm_addr,
    input wire [15:0] dx_addr,
    input wire        dx_we,
    input wire        dx_re,
    input wire [15:0] dy_addr,
    input wire        dy_re,
    input wire        dma_region_hit,
    input wire        psv_enable,
    input wire [22:0] irq_vector,
    input wire        irq_ack,
    input wire [39:0] acc_a,
    input wire [39:0] acc_b
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Every X access inside the DMA block must be flagged
    property p_dma_in;
        (dx_re || dx_we) && dx_addr >= 16'h4000 && dx_addr <= 16'h47ff
            |-> dma_region_hit;
    endproperty
    a_dma_in: assert property (p_dma_in) else $error("dma flag low");
    property p_rst_out;
        $past(reset) |-> pm_addr == 23'h0 && acc_a == 40'h0 && acc_b == 40'h0;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("bad reset");
    // Prefetch walks one word per edge after release
    property p_fetch;
        $fell(reset) |-> ##1 pm_addr == 23'h000002;
    endproperty
    a_fetch: assert property (p_fetch) else $error("no prefetch");
    property p_rst_strobe;
        $past(reset) |-> !dx_we && !dx_re && !dy_re && !irq_ack;
    endproperty
    a_rst_strobe: assert property (p_rst_strobe) else $error("strobe");
    property p_dy_base;
        dy_re |-> dy_addr >= Y_BASE;
    endproperty
    a_dy_base: assert property (p_dy_base) else $error("y read low");
    // A write into the program window is dropped, never strobed
    property p_psv_store;
        dx_we && psv_enable |-> !dx_addr[15];
    endproperty
    a_psv_store: assert property (p_psv_store) else $error("psv wr");
    property p_ack_pulse;
        irq_ack |=> !irq_ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
    property p_irq_vec;
        irq_ack |-> ##[1:3] pm_addr == irq_vector;
    endproperty
    a_irq_vec: assert property (p_irq_vec) else $error("no vector");
endmodule // dcd_chk

// File: dsp_cpu_datapath_bench.sv
`timescale 1ns/10ps
// ****************************************
// Bench top
// ****************************************
module dsp_cpu_datapath_bench;
    reg         clk_sys = 1'b0;
    reg         reset = 1'b1;
    reg         psv_enable = 1'b1;
    reg  [7:0]  program_window_page = 8'h01;
    reg         irq = 1'b0;
    reg  [22:0] irq_vector = 23'h000020;
    wire [22:0] pm_addr;
    wire [15:0] dx_addr, dx_wdata, dy_addr;
    wire        dx_we, dx_re, dy_re, dma_region_hit, irq_ack;
    wire [39:0] acc_a, acc_b;
    reg  [23:0] rom [0:31];
    reg  [15:0] xm [0:16383];
    reg  [15:0] push_addr, push_hi;
    reg         acked;
    integer     errors = 0;
    integer     checks = 0;
    integer     i;
    // Sums, MACs, window load, then a branch to itself at 0x20
    reg  [23:0] prog [0:16] = '{24'hc14000, 24'hc21234, 24'hc30101,
        24'h122300, 24'h321000, 24'hc40007, 24'hc50006, 24'h400000,
        24'h480000, 24'hca2000, 24'h420000, 24'h400000, 24'hc68004,
        24'hc94002, 24'h276000, 24'h379000, 24'h600010};
    // Memories answer in the same cycle, as the core expects
    wire [23:0] pm_rdata = rom[pm_addr[5:1]];
    wire [15:0] dx_rdata = xm[dx_addr[14:1]];
    wire [15:0] dy_rdata = xm[dy_addr[14:1]];
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (dx_we) begin
            xm[dx_addr[14:1]] <= dx_wdata;
        end
    end
    // Modulo and bit-reverse bounds are left idle
    dsp_cpu_datapath dut (.clk_sys, .reset, .pm_addr, .pm_rdata, .dx_addr,
        .dx_rdata, .dx_wdata, .dx_we, .dx_re, .dy_addr, .dy_rdata, .dy_re,
        .dma_region_hit, .psv_enable, .program_window_page,
        .xmod_start(16'h0000), .xmod_end(16'h0000), .ymod_start(16'h0000),
        .ymod_end(16'h0000), .rev_mod(16'h0000), .irq, .irq_vector,
        .irq_ack, .acc_a, .acc_b);
    task cmp(input string n, input [39:0] e, input [39:0] g);
        begin
            checks = checks + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("unexpected %s exp %h got %h", n, e, g);
            end
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d errors %0d", checks, errors);
            if (errors == 0 && checks > 0) begin
                $display("NO MISMATCHES");
            end else begin
                $display("MISMATCHES SEEN");
            end
            $finish;
        end
    endtask
    // Run the fixed program to its closing loop and inspect the results
    task t_program;
        begin
            repeat (44) @(posedge clk_sys);
            // Look between edges, once the branch word has just executed
            @(negedge clk_sys);
            cmp("dma word", 40'h1335, {24'h0, xm[14'h2000]});
            cmp("window word", 40'h0101, {24'h0, xm[14'h2001]});
            cmp("acc a", 40'h84, acc_a);
            cmp("acc b", 40'h2a, acc_b);
            cmp("loop pc", 40'h20, {17'h0, pm_addr});
            $display("program test done");
        end
    endtask
    // Raise the request on an edge and hold it until acknowledged; the
    // low push shows in the very first cycle, so sample before the edge
    task t_irq;
        begin
            acked = 1'b0;
            push_addr = 16'hffff;
            push_hi = 16'hffff;
            @(posedge clk_sys);
            irq <= 1'b1;
            for (i = 0; i < 12; i = i + 1) begin
                @(negedge clk_sys);
                acked = acked | (irq_ack === 1'b1);
                if (dx_we === 1'b1 && push_addr !== 16'hffff &&
                    push_hi === 16'hffff)
                    push_hi = dx_addr;
                if (dx_we === 1'b1 && push_addr === 16'hffff)
                    push_addr = dx_addr;
                @(posedge clk_sys);
                if (acked) irq <= 1'b0;
            end
            cmp("irq ack", 40'h1, {39'h0, acked});
            cmp("push addr", 40'h0800, {24'h0, push_addr});
            cmp("push hi addr", 40'h0802, {24'h0, push_hi});
            cmp("pushed pc", 40'h20, {24'h0, xm[14'h0400]});
            $display("interrupt test done");
        end
    endtask
    initial begin
        for (i = 0; i < 32; i = i + 1) rom[i] = (i < 17) ? prog[i] : prog[16];
        xm[0] = 16'h0003;
        xm[14'h1000] = 16'h0010;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        t_program;
        t_irq;
        print_verdict;
    end
    // Both tests need well under 100 cycles
    initial begin
        #(25 * 400);
        errors = errors + 1;
        print_verdict;
    end
endmodule // dsp_cpu_datapath_bench
bind dsp_cpu_datapath dcd_chk #(.Y_BASE(Y_BASE)) u_chk (.clk_sys, .reset,
    .pm_addr, .dx_addr, .dx_we, .dx_re, .dy_addr, .dy_re, .dma_region_hit,
    .psv_enable, .irq_vector, .irq_ack, .acc_a, .acc_b);
